/* sensor_spi_slave_port.sv */
// Serial slave port giving a host byte-wise access to the sensor register map.
//
// Functional notes
// - A write frame is a run of pairs, each a control byte then one data byte.
// - A read frame is one control byte followed by data bytes while clocking lasts.
// - During a read the address steps up by one after every data byte.
// - The port works in three-wire mode unless the four-wire select bit is 1.
// - Three-wire mode uses clock, select and one shared data line both ways.
// - In three-wire mode incoming bits are taken on rising clock edges.
// - In three-wire mode outgoing bits change on rising edges.
// - A three-wire read has one extra clock after the control byte before data.
// - The control byte is the direction flag, 1 for read, then seven address bits.
// - Every byte is shifted most significant bit first.
// - In four-wire mode input is taken on rising and output changes on falling edges.
// - Only addresses up to 15h are served; others leave the data line released.
`timescale 1ns/100ps
module sensor_spi_slave_port #(
   parameter int FIFO_DEPTH = sensor_spi_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   // Mode control from the register map.
   input  wire logic                                four_wire_select,
   // Serial pins.
   input  wire logic                                sck_in,
   input  wire logic                                csb_n_in,
   input  wire logic                                sdi_in,
   output logic                                     sdi_out,
   output logic                                     sdi_oe,
   output logic                                     sdo_out,
   output logic                                     sdo_oe,
   // Write words toward the register map.
   output logic                                     wr_valid,
   input  wire logic                                wr_ready,
   output logic [sensor_spi_pkg::ADDR_W-1:0]        wr_addr,
   output logic [sensor_spi_pkg::DATA_W-1:0]        wr_data,
   output logic                                     wr_overflow,
   // Read access into the register map.
   output logic [sensor_spi_pkg::ADDR_W-1:0]        rd_addr,
   input  wire logic [sensor_spi_pkg::DATA_W-1:0]   rd_data,
   output logic                                     rd_take
);
   localparam int AW = sensor_spi_pkg::ADDR_W;
   localparam int DW = sensor_spi_pkg::DATA_W;
   localparam int WW = sensor_spi_pkg::WORD_W;

   logic                    sck_s1_ff;
   logic                    sck_s2_ff;
   logic                    sck_s3_ff;
   logic                    csb_s1_ff;
   logic                    csb_s2_ff;
   logic                    sdi_s1_ff;
   logic                    sdi_s2_ff;
   logic                    mode_4w_ff;
   sensor_spi_pkg::phase_t  phase_ff;
   logic [2:0]              bit_cnt_ff;
   logic [DW-1:0]           shift_in_ff;
   logic [AW-1:0]           addr_ff;
   logic [DW-1:0]           out_sr_ff;
   logic [3:0]              out_cnt_ff;
   logic                    out_en_ff;
   logic                    overflow_ff;
   logic                    sck_rise;
   logic                    sck_fall;
   logic                    frame_idle;
   logic [DW-1:0]           in_byte;
   logic                    byte_done;
   logic                    ctrl_done;
   logic                    wdat_done;
   logic                    drive_evt;
   logic                    load_evt;
   logic                    push_valid;
   logic                    push_ready;
   logic [WW-1:0]           push_word;
   logic [WW-1:0]           pop_word;

   // Pins come from the host clock domain; two stages before any use.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sck_s1_ff <= sensor_spi_pkg::SCK_IDLE;
         sck_s2_ff <= sensor_spi_pkg::SCK_IDLE;
         sck_s3_ff <= sensor_spi_pkg::SCK_IDLE;
         csb_s1_ff <= sensor_spi_pkg::CSB_IDLE;
         csb_s2_ff <= sensor_spi_pkg::CSB_IDLE;
         sdi_s1_ff <= 1'b0;
         sdi_s2_ff <= 1'b0;
      end
      else
      begin
         sck_s1_ff <= sck_in;
         sck_s2_ff <= sck_s1_ff;
         sck_s3_ff <= sck_s2_ff;
         csb_s1_ff <= csb_n_in;
         csb_s2_ff <= csb_s1_ff;
         sdi_s1_ff <= sdi_in;
         sdi_s2_ff <= sdi_s1_ff;
      end
   end

   // Edges are found after synchronisation, so data and clock share latency.
   assign sck_rise   = sck_s2_ff && !sck_s3_ff;
   assign sck_fall   = !sck_s2_ff && sck_s3_ff;
   assign frame_idle = csb_s2_ff;
   assign in_byte    = {shift_in_ff[DW-2:0], sdi_s2_ff};

   // Byte completion in the receiving phases.
   assign byte_done = !frame_idle && sck_rise && (bit_cnt_ff == sensor_spi_pkg::BIT_LAST)
                      && (phase_ff != sensor_spi_pkg::PH_RDATA);
   assign ctrl_done = byte_done && (phase_ff == sensor_spi_pkg::PH_CTRL);
   assign wdat_done = byte_done && (phase_ff == sensor_spi_pkg::PH_WDATA);

   assign drive_evt = !frame_idle && (phase_ff == sensor_spi_pkg::PH_RDATA)
                      && (mode_4w_ff ? sck_fall : sck_rise);
   assign load_evt  = drive_evt && (out_cnt_ff == sensor_spi_pkg::OUT_DONE);

   // mode select latch
   // The mode is frozen during a frame so a mid-frame change cannot split a byte.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         mode_4w_ff <= 1'b0;
      end
      else if (frame_idle)
      begin
         mode_4w_ff <= four_wire_select;
      end
   end

   // rising edge sampling
   // Phase sequencing and input shifting; bits seen in a read stream are ignored.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         phase_ff    <= sensor_spi_pkg::PH_CTRL;
         bit_cnt_ff  <= sensor_spi_pkg::BIT_FIRST;
         shift_in_ff <= '0;
      end
      else if (frame_idle)
      begin
         phase_ff    <= sensor_spi_pkg::PH_CTRL;
         bit_cnt_ff  <= sensor_spi_pkg::BIT_FIRST;
         shift_in_ff <= '0;
      end
      else
      begin
         case (phase_ff)
            sensor_spi_pkg::PH_CTRL:
            begin
               if (sck_rise)
               begin
                  shift_in_ff <= in_byte;
                  bit_cnt_ff  <= bit_cnt_ff + 1'b1;
               end
               if (ctrl_done)
               begin
                  phase_ff <= (in_byte[sensor_spi_pkg::RW_BIT] == sensor_spi_pkg::RW_READ)
                              ? sensor_spi_pkg::PH_RDATA : sensor_spi_pkg::PH_WDATA;
               end
            end
            sensor_spi_pkg::PH_WDATA:
            begin
               if (sck_rise)
               begin
                  shift_in_ff <= in_byte;
                  bit_cnt_ff  <= bit_cnt_ff + 1'b1;
               end
               if (wdat_done)
               begin
                  phase_ff <= sensor_spi_pkg::PH_CTRL;
               end
            end
            sensor_spi_pkg::PH_RDATA:
            begin
               phase_ff <= sensor_spi_pkg::PH_RDATA;
            end
            default:
            begin
               phase_ff <= sensor_spi_pkg::PH_CTRL;
            end
         endcase
      end
   end

   // read auto increment
   // The address steps as each byte is loaded, so the next byte is ready in time.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         addr_ff <= '0;
      end
      else if (ctrl_done)
      begin
         addr_ff <= in_byte[AW-1:0];
      end
      else if (load_evt)
      begin
         addr_ff <= addr_ff + 1'b1;
      end
   end

   // out of range release
   // In three-wire mode the count starts full, so the extra clock loads the first byte.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         out_sr_ff  <= '0;
         out_cnt_ff <= sensor_spi_pkg::OUT_DONE;
         out_en_ff  <= 1'b0;
      end
      else if (frame_idle)
      begin
         out_sr_ff  <= '0;
         out_cnt_ff <= sensor_spi_pkg::OUT_DONE;
         out_en_ff  <= 1'b0;
      end
      else if (load_evt)
      begin
         out_sr_ff  <= rd_data;
         out_cnt_ff <= sensor_spi_pkg::OUT_FIRST;
         out_en_ff  <= (addr_ff <= sensor_spi_pkg::MAX_ADDR);
      end
      else if (drive_evt)
      begin
         out_sr_ff  <= {out_sr_ff[DW-2:0], 1'b0};
         out_cnt_ff <= out_cnt_ff + 1'b1;
      end
   end

   assign sdi_out = out_sr_ff[DW-1];
   assign sdo_out = out_sr_ff[DW-1];
   assign sdi_oe  = out_en_ff && !mode_4w_ff;
   assign sdo_oe  = out_en_ff && mode_4w_ff;
   assign rd_addr = addr_ff;
   assign rd_take = load_evt;

   // write pair push
   // The serial link cannot be stalled, so a word meeting a full buffer is dropped.
   assign push_valid = wdat_done && (addr_ff <= sensor_spi_pkg::MAX_ADDR);
   assign push_word  = {addr_ff, in_byte};

   // Overflow is flagged for one cycle when a completed pair finds no room.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         overflow_ff <= 1'b0;
      end
      else
      begin
         overflow_ff <= push_valid && !push_ready;
      end
   end
   assign wr_overflow = overflow_ff;

   // Write words wait here until the register map accepts them.
   spi_word_fifo #(
      .WIDTH (WW),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_word),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (pop_word)
   );
   assign wr_addr = pop_word[WW-1:DW];
   assign wr_data = pop_word[DW-1:0];

   // Checks on the design's own behaviour.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_ctrl_read3;
      ctrl_done && in_byte[sensor_spi_pkg::RW_BIT] && !mode_4w_ff;
   endsequence

   sequence s_wr_pair_end;
      wdat_done && (addr_ff <= sensor_spi_pkg::MAX_ADDR) && push_ready;
   endsequence

   a_frame_abort_clear: assert property (frame_idle |=> (bit_cnt_ff == sensor_spi_pkg::BIT_FIRST)
      && (phase_ff == sensor_spi_pkg::PH_CTRL) && !sdi_oe && !sdo_oe)
      else $error("frame state not cleared while select high");

   a_idle_no_drive: assert property ((phase_ff != sensor_spi_pkg::PH_RDATA)
      |-> !sdi_oe && !sdo_oe)
      else $error("data line driven outside read data");

   a_rise_sample_shift: assert property ((sck_rise && !frame_idle
      && (phase_ff == sensor_spi_pkg::PH_CTRL)) |=> shift_in_ff == $past(in_byte))
      else $error("input bit not shifted on rising edge");

   a_mode_pin_use: assert property ((sdi_oe |-> !mode_4w_ff)
      and (sdo_oe |-> mode_4w_ff))
      else $error("wrong data pin driven for the mode");

   a_reset_three_wire: assert property ($rose(mode_4w_ff) |-> $past(four_wire_select)
      && $past(frame_idle))
      else $error("four-wire mode entered without select bit");

   a_three_wire_extra: assert property (s_ctrl_read3 |=> !sdi_oe
      && (out_cnt_ff == sensor_spi_pkg::OUT_DONE) [*2])
      else $error("three-wire read drove before the extra clock");

   a_drive_edge_match: assert property (load_evt |-> (mode_4w_ff ? sck_fall : sck_rise))
      else $error("read data changed on the wrong clock edge");

   a_four_wire_fall: assert property ((drive_evt && mode_4w_ff) |-> !sck_s2_ff && sck_s3_ff)
      else $error("four-wire output moved off falling edge");

   a_read_addr_step: assert property (load_evt |=> rd_addr == $past(rd_addr) + 7'h01)
      else $error("read address did not increment");

   a_msb_out_first: assert property (load_evt |=> sdi_out == $past(rd_data[7]))
      else $error("first output bit is not the msb");

   a_range_release: assert property ((load_evt && (addr_ff > sensor_spi_pkg::MAX_ADDR))
      |=> !sdi_oe && !sdo_oe)
      else $error("line driven for out of range address");

   a_read_phase_hold: assert property ((ctrl_done && in_byte[7])
      |=> (phase_ff == sensor_spi_pkg::PH_RDATA) throughout (!frame_idle [*1]))
      else $error("read control byte did not enter read stream");

   a_write_pair_push: assert property (s_wr_pair_end |-> ##[1:2] wr_valid)
      else $error("completed write pair not offered");

   a_rw_write_phase: assert property ((ctrl_done && !in_byte[7])
      |=> phase_ff == sensor_spi_pkg::PH_WDATA)
      else $error("write flag did not select write data");
endmodule // sensor_spi_slave_port

/* sensor_spi_pkg.sv */
// Shared constants and types of the sensor serial slave port.
package sensor_spi_pkg;
   // Field widths of the control and data bytes.
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int WORD_W = ADDR_W + DATA_W;

   // Highest register address that the port serves.
   localparam logic [ADDR_W-1:0] MAX_ADDR = 7'h15;

   // Bit position of the direction flag in the control byte, and its read value.
   localparam int  RW_BIT  = 7;
   localparam logic RW_READ = 1'b1;

   // Bit counting inside a byte.
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam logic [3:0] OUT_FIRST = 4'h1;
   localparam logic [3:0] OUT_DONE  = 4'h8;

   // Reset levels of the synchronised pins; the clock idles high in mode 3.
   localparam logic SCK_IDLE = 1'b1;
   localparam logic CSB_IDLE = 1'b1;

   // Default depth of the write word buffer.
   localparam int FIFO_DEPTH = 8;

   // Frame phase: control byte, write data byte, or read data stream.
   typedef enum logic [1:0] {
      PH_CTRL,
      PH_WDATA,
      PH_RDATA
   } phase_t;
endpackage

/* spi_word_fifo.sv */
// Word buffer with registered output stage and valid/ready on both sides.
`timescale 1ns/100ps
module spi_word_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [CNT_W-1:0] count_ff;
   logic             out_valid_ff;
   logic [WIDTH-1:0] out_data_ff;
   logic             push;
   logic             pop;

   // The output register refills whenever storage holds a word and the register is empty or being drained.
   assign in_ready  = (count_ff != CNT_FULL);
   assign push      = in_valid && in_ready;
   assign pop       = (count_ff != '0) && (!out_valid_ff || out_ready);
   assign out_valid = out_valid_ff;
   assign out_data  = out_data_ff;

   // Storage array; no reset needed since the count guards every read.
   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   // Pointers and fill count.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop)
         begin
            count_ff <= count_ff + 1'b1;
         end
         else if (pop && !push)
         begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

   // Registered output word.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         out_valid_ff <= 1'b0;
         out_data_ff  <= '0;
      end
      else if (pop)
      begin
         out_valid_ff <= 1'b1;
         out_data_ff  <= mem_ff[rd_ptr_ff];
      end
      else if (out_ready)
      begin
         out_valid_ff <= 1'b0;
      end
   end
endmodule // spi_word_fifo

/* sensor_spi_host_model.sv */
// Host master model that frames bytes onto the sensor port's serial pins.
`timescale 1ns/100ps
module sensor_spi_host_model (
   // Clock and mode.
   input  wire logic core_clk,
   input  wire logic four,
   // Serial pins of the port.
   output logic      sck_in,
   output logic      csb_n_in,
   output logic      sdi_in,
   input  wire logic sdi_out,
   input  wire logic sdi_oe,
   input  wire logic sdo_out,
   input  wire logic sdo_oe
);
   logic host_oe   = 1'b0;
   logic host_bit  = 1'b0;
   logic float_bit = 1'b0;
   logic clash     = 1'b0;

   // A released line toggles every cycle, so a stale bit never passes for data.
   always @(posedge core_clk)
   begin
      float_bit <= ~float_bit;
      if ((sdi_oe && (host_oe || four)) || (sdo_oe && !four))
         clash <= 1'b1;
   end

   always_comb
   begin
      if (sdi_oe && !four)
         sdi_in = sdi_out;
      else if (host_oe)
         sdi_in = host_bit;
      else
         sdi_in = float_bit;
   end

   // The clock idles high and the select starts released.
   initial
   begin
      sck_in   = 1'b1;
      csb_n_in = 1'b1;
   end

   // Half of one serial clock period, 20 core cycles.
   task automatic half();
      repeat (20) @(posedge core_clk);
   endtask

   // Select moves only while the clock is high.
   task automatic start();
      csb_n_in <= 1'b0;
      half();
   endtask

   task automatic stop();
      host_oe <= 1'b0;
      half();
      csb_n_in <= 1'b1;
      half();
      half();
   endtask

   task automatic send(input logic [7:0] b, input int nbits);
      for (int i = 7; i > 7 - nbits; i--)
      begin
         sck_in   <= 1'b0;
         host_oe  <= 1'b1;
         host_bit <= b[i];
         half();
         sck_in <= 1'b1;
         half();
      end
   endtask

   task automatic spare();
      sck_in  <= 1'b0;
      host_oe <= 1'b0;
      half();
      sck_in <= 1'b1;
      half();
   endtask

   // bits captured just before each rising edge
   task automatic recv(output logic [7:0] b, output int drv);
      drv = 0;
      for (int i = 7; i >= 0; i--)
      begin
         sck_in  <= 1'b0;
         host_oe <= 1'b0;
         half();
         b[i] = four ? (sdo_oe ? sdo_out : float_bit) : sdi_in;
         drv += four ? int'(sdo_oe) : int'(sdi_oe);
         sck_in <= 1'b1;
         half();
      end
   endtask
endmodule // sensor_spi_host_model

/* sensor_spi_slave_port_bench.sv */
// Self-checking bench of the sensor serial slave port.
`timescale 1ns/100ps
module sensor_spi_slave_port_bench;
   logic                              core_clk, rst, four_wire_select, wr_ready, hold;
   logic                              sck_in, csb_n_in, sdi_in, sdi_out, sdi_oe;
   logic                              sdo_out, sdo_oe, wr_valid, wr_overflow, rd_take;
   logic [sensor_spi_pkg::ADDR_W-1:0] wr_addr, rd_addr;
   logic [sensor_spi_pkg::DATA_W-1:0] wr_data, rd_data;
   logic [7:0]                        regs [128];
   logic [14:0]                       exp_q [$];
   logic [31:0]                       seed = 32'h31;
   int                                n_errors, n_compared, n_ovf, n_take, cyc;

   sensor_spi_slave_port i_dut (
      .core_clk(core_clk), .rst(rst), .four_wire_select(four_wire_select),
      .sck_in(sck_in), .csb_n_in(csb_n_in), .sdi_in(sdi_in), .sdi_out(sdi_out),
      .sdi_oe(sdi_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_overflow(wr_overflow), .rd_addr(rd_addr), .rd_data(rd_data), .rd_take(rd_take));

   sensor_spi_host_model i_host (
      .core_clk(core_clk), .four(four_wire_select), .sck_in(sck_in),
      .csb_n_in(csb_n_in), .sdi_in(sdi_in), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe));

   // The register map answers in the same cycle as the read address.
   assign rd_data = regs[rd_addr];

   // Core clock at 250 MHz.
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Repeatable xorshift source.
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // One comparison, reported at once on mismatch.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Random stalls on the write side, word checks, overflow count and a hang limit.
   always @(posedge core_clk)
   begin
      cyc++;
      wr_ready <= !hold && (xs() % 2 == 1);
      if (!rst && wr_valid === 1'b1 && wr_ready === 1'b1)
         chk({1'b0, wr_addr, wr_data}, exp_q.size() ? {1'b0, exp_q.pop_front()} : 16'hFFFF);
      if (wr_overflow === 1'b1)
         n_ovf++;
      // Every byte loaded into the output shifter is one read strobe.
      if (rd_take === 1'b1)
         n_take++;
      if (cyc == 60000)
      begin
         n_errors++;
         test_done();
      end
   end

   // Read frame of n bytes starting at a; beyond 15h the line must stay released.
   task automatic rd(input logic [6:0] a, input int n);
      logic [7:0] b;
      logic [6:0] x;
      int         d;
      int         t;
      t = n_take;
      i_host.start();
      i_host.send({1'b1, a}, 8);
      if (!four_wire_select)
         i_host.spare();
      for (int i = 0; i < n; i++)
      begin
         x = a + 7'(i);
         i_host.recv(b, d);
         if (x <= sensor_spi_pkg::MAX_ADDR)
            chk(b, regs[x]);
         chk(16'(d), (x <= sensor_spi_pkg::MAX_ADDR) ? 16'h0008 : 16'h0000);
      end
      i_host.stop();
      // Three-wire reads also preload one byte on the last rising edge of the frame.
      chk(16'(n_take - t), four_wire_select ? 16'(n) : 16'(n + 1));
   endtask

   // Write frame of n pairs; only the first keep in-range words are expected.
   task automatic wr(input int n, input int keep, input int lim);
      logic [6:0] a;
      logic [7:0] v;
      int         k;
      k = 0;
      i_host.start();
      for (int i = 0; i < n; i++)
      begin
         a = 7'(xs() % lim);
         v = 8'(xs());
         if (a <= sensor_spi_pkg::MAX_ADDR && k < keep)
            exp_q.push_back({a, v});
         if (a <= sensor_spi_pkg::MAX_ADDR)
            k++;
         i_host.send({1'b0, a}, 8);
         i_host.send(v, 8);
      end
      i_host.stop();
   endtask

   // Wait, bounded, until every expected word has come out.
   task automatic drain();
      repeat (20) @(posedge core_clk);
      for (int i = 0; i < 500 && exp_q.size() > 0; i++)
         @(posedge core_clk);
      chk(16'(exp_q.size()), 16'h0000);
   endtask

   // Main sequence: both modes, two aborted frames, then a full buffer.
   initial
   begin
      rst = 1'b1;
      four_wire_select = 1'b0;
      hold = 1'b0;
      wr_ready = 1'b0;
      foreach (regs[i])
         regs[i] = 8'(xs());
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({sdi_oe, sdo_oe, wr_valid}, 16'h0000);
      for (int m = 0; m < 2; m++)
      begin
         four_wire_select <= m[0];
         repeat (4) @(posedge core_clk);
         rd(7'h14, 3);
         for (int k = 0; k < 3; k++)
            rd(7'(xs() % 20), 2 + k);
         wr(6, 99, 24);
         drain();
         $display("test mode %0d done", m);
      end
      i_host.start();
      i_host.send(8'h05, 8);
      i_host.send(8'hA5, 4);
      i_host.stop();
      i_host.start();
      i_host.send(8'h85, 3);
      i_host.stop();
      rd(7'h05, 2);
      drain();
      $display("test abort done");
      hold <= 1'b1;
      n_ovf = 0;
      // All ten pairs in range: nine fit the buffer and its output stage, one is dropped.
      wr(10, 9, 16);
      repeat (10) @(posedge core_clk);
      chk(16'(n_ovf), 16'h0001);
      hold <= 1'b0;
      drain();
      chk(i_host.clash, 16'h0000);
      $display("test overflow done");
      test_done();
   end
endmodule // sensor_spi_slave_port_bench
